// ---- include/bus_arb_pkg.sv ----
package bus_arb_pkg;

    // processor request lines on the shared bus
    localparam int NUM_PROCS = 6;
    localparam int ID_W = 3;

    // straps are taken once the pin filter has settled after reset
    // the filter output is settled after four edges, so the fifth reads it
    localparam logic [2:0] STRAP_SETTLE_CYCLES = 3'h4;

    // reset values
    localparam logic [2:0] MASTER_RST = 3'h0;
    localparam logic [2:0] LAST_RST = 3'h0;
    localparam logic [2:0] ID_RST = 3'h0;
    localparam logic [2:0] SINGLE_PROC_ID = 3'h0;
    localparam logic PIN_IDLE = 1'b1;

    typedef enum logic [1:0] {
        ST_ARB = 2'b00,
        ST_RELEASE = 2'b01,
        ST_HOST = 2'b10
    } host_state_t;

    // asynchronous pin inputs, all active low except id and rotate select
    typedef struct packed {
        logic host_bus_req_n;
        logic chip_sel_n;
        logic rotating_priority_sel;
        logic core_access_override_n;
        logic [NUM_PROCS-1:0] proc_bus_req_line;
        logic [ID_W-1:0] processor_number_straps;
        logic ext_dma_req_a;
        logic ext_dma_req_b;
    } pin_bundle_t;

    localparam int PIN_W = $bits(pin_bundle_t);
    localparam logic [PIN_W-1:0] PIN_RST = {4'hd, 6'h3f, 3'h0, 2'h3};

endpackage

// ---- rtl/pin_filter.sv ----
`timescale 1ns/1ns
module pin_filter
    import bus_arb_pkg::*;
#(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);

    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;

    // s1 only feeds s2; a bit moves on once s2 and s3 agree
    always_ff @(posedge mclk) begin
        if (rst) begin
            s1_q <= RST_VAL;
            s2_q <= RST_VAL;
            s3_q <= RST_VAL;
            dout <= RST_VAL;
        end else if (clk_en) begin
            s1_q <= din;
            s2_q <= s1_q;
            s3_q <= s2_q;
            for (int i = 0; i < W; i++) begin
                if (s2_q[i] == s3_q[i]) begin
                    dout[i] <= s3_q[i];
                end
            end
        end
    end

endmodule

// ---- rtl/host_multiproc_bus_arbiter.sv ----
`timescale 1ns/1ns
// Function
// - master yields bus, then asserts host grant
// - yielding floats address, data, selects, strobes
// - host request beats every processor request
// - grant held low until host request released
// - current master drives host grant, line 1 or a lone part when there is no master
// - acknowledge low inserts host wait states
// - acknowledge open drain unless active drive selected
// - acknowledge driven only with select and request
// - external request a serviced by channel 7
// - external request b serviced by channel 6
// - drive own request line, sample all others
// - straps pick own line, zero means single
// - rotate select high rotates, low fixed priority
// - core override suspends master background transfers
// - one arbitration decision per input clock
module host_multiproc_bus_arbiter
    import bus_arb_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic host_bus_req_n,
    input wire logic chip_sel_n,
    input wire logic host_bus_grant_n_i,
    output logic host_bus_grant_n_o,
    output logic host_bus_grant_n_oe,
    output logic host_access_ack_o,
    output logic host_access_ack_oe,
    input wire logic host_access_busy,
    input wire logic ack_active_drive_sel,
    input wire logic [NUM_PROCS-1:0] proc_bus_req_line_i,
    output logic [NUM_PROCS-1:0] proc_bus_req_line_o,
    output logic [NUM_PROCS-1:0] proc_bus_req_line_oe,
    input wire logic [ID_W-1:0] processor_number_straps,
    input wire logic rotating_priority_sel,
    input wire logic core_access_override_n_i,
    output logic core_access_override_n_o,
    output logic core_access_override_n_oe,
    input wire logic core_wants_bus,
    input wire logic dma_wants_bus,
    output logic bus_drive_en,
    output logic is_master,
    output logic dma_suspend,
    input wire logic ext_dma_req_a,
    input wire logic ext_dma_req_b,
    output logic ext_dma_grant_a,
    output logic ext_dma_grant_a_oe,
    output logic ext_dma_grant_b,
    output logic ext_dma_grant_b_oe,
    output logic dma_ch7_req,
    output logic dma_ch6_req,
    input wire logic dma_ch7_grant,
    input wire logic dma_ch6_grant
);

    ////////////////////////////////////////////////////////////////////////////////
    // pin conditioning

    pin_bundle_t pins_raw;
    pin_bundle_t pins_f;
    logic [PIN_W-1:0] pins_f_vec;

    assign pins_raw = '{host_bus_req_n: host_bus_req_n, chip_sel_n: chip_sel_n,
                        rotating_priority_sel: rotating_priority_sel,
                        core_access_override_n: core_access_override_n_i,
                        proc_bus_req_line: proc_bus_req_line_i,
                        processor_number_straps: processor_number_straps,
                        ext_dma_req_a: ext_dma_req_a, ext_dma_req_b: ext_dma_req_b};

    pin_filter #(.W(PIN_W), .RST_VAL(PIN_RST)) u_pin_filter (
        .mclk(mclk),
        .rst(rst),
        .clk_en(clk_en),
        .din(pins_raw),
        .dout(pins_f_vec)
    );

    assign pins_f = pin_bundle_t'(pins_f_vec);

    logic host_req_s;
    logic chip_sel_s;
    logic cpa_seen;
    logic [NUM_PROCS-1:0] br_req;

    assign host_req_s = ~pins_f.host_bus_req_n;
    assign chip_sel_s = ~pins_f.chip_sel_n;
    assign cpa_seen = ~pins_f.core_access_override_n;
    assign br_req = ~pins_f.proc_bus_req_line;

    ////////////////////////////////////////////////////////////////////////////////
    // strap capture: taken once after reset, then frozen, since the
    // system only changes them while reset is held

    logic [2:0] settle_q;
    logic loaded_q;
    logic [ID_W-1:0] id_q;
    logic [NUM_PROCS-1:0] own_mask;

    always_ff @(posedge mclk) begin
        if (rst) begin
            settle_q <= '0;
            loaded_q <= 1'b0;
            id_q <= ID_RST;
        end else if (clk_en && !loaded_q) begin
            settle_q <= settle_q + 3'h1;
            if (settle_q == STRAP_SETTLE_CYCLES) begin
                loaded_q <= 1'b1;
                id_q <= pins_f.processor_number_straps;
            end
        end
    end

    always_comb begin
        own_mask = '0;
        for (int i = 0; i < NUM_PROCS; i++) begin
            if (id_q == 3'(i + 1)) begin
                own_mask[i] = 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // distributed arbitration; every processor runs the same choice on
    // the same sampled lines, so all agree on the master

    function automatic logic [2:0] pick(input logic [NUM_PROCS-1:0] req,
                                        input logic [2:0] start);
        logic [2:0] idx;
        logic found;
        pick = 3'h0;
        found = 1'b0;
        for (int k = 1; k <= NUM_PROCS; k++) begin
            idx = 3'(((int'(start) + k - 1) % NUM_PROCS) + 1);
            if (!found && req[idx - 3'h1]) begin
                pick = idx;
                found = 1'b1;
            end
        end
    endfunction

    host_state_t st_q;
    logic [2:0] mst_q;
    logic [2:0] last_q;
    logic [2:0] winner;
    logic mst_holds;

    assign mst_holds = (mst_q != 3'h0) && br_req[mst_q - 3'h1];
    // fixed starts the search at line 1; rotating starts just past the
    // last master, which leaves it lowest
    assign winner = pick(br_req, pins_f.rotating_priority_sel ? last_q : 3'h0);

    always_ff @(posedge mclk) begin
        if (rst) begin
            mst_q <= MASTER_RST;
            last_q <= LAST_RST;
        end else if (clk_en && loaded_q && st_q == ST_ARB && !host_req_s) begin
            if (!mst_holds) begin
                mst_q <= winner;
                if (winner != 3'h0) begin
                    last_q <= winner;
                end
            end
        end
    end

    assign is_master = loaded_q && ((id_q == SINGLE_PROC_ID) || (mst_q == id_q));

    ////////////////////////////////////////////////////////////////////////////////
    // own request line and core override

    logic want_q;

    always_ff @(posedge mclk) begin
        if (rst) begin
            want_q <= 1'b0;
        end else if (clk_en) begin
            want_q <= core_wants_bus || dma_wants_bus;
        end
    end

    assign proc_bus_req_line_oe = loaded_q ? own_mask : '0;
    assign proc_bus_req_line_o = ~(own_mask & {NUM_PROCS{want_q}});

    // open drain: a slave core pulls low, the master never does
    assign core_access_override_n_oe = loaded_q && !is_master && core_wants_bus;
    assign core_access_override_n_o = 1'b0;
    assign dma_suspend = is_master && cpa_seen && dma_wants_bus;

    ////////////////////////////////////////////////////////////////////////////////
    // host hand-over

    logic grant_q;
    logic owner_q;

    always_ff @(posedge mclk) begin
        if (rst) begin
            st_q <= ST_ARB;
            grant_q <= 1'b0;
            owner_q <= 1'b0;
        end else if (clk_en && loaded_q) begin
            case (st_q)
                ST_ARB: begin
                    if (host_req_s) begin
                        st_q <= ST_RELEASE;
                        // with no master, line 1 (or a lone part) answers the host
                        owner_q <= is_master || (mst_q == 3'h0 && id_q <= 3'h1);
                    end
                end
                ST_RELEASE: begin
                    st_q <= ST_HOST;
                    grant_q <= 1'b1;
                end
                ST_HOST: begin
                    if (!host_req_s) begin
                        st_q <= ST_ARB;
                        grant_q <= 1'b0;
                        owner_q <= 1'b0;
                    end
                end
                default: begin
                    st_q <= ST_ARB;
                end
            endcase
        end
    end

    // the bus floats as soon as the host request is seen, two cycles ahead of grant
    assign bus_drive_en = is_master && st_q == ST_ARB && !host_req_s;
    assign host_bus_grant_n_oe = owner_q;
    assign host_bus_grant_n_o = ~grant_q;

    ////////////////////////////////////////////////////////////////////////////////
    // host access acknowledge

    logic ack_en;
    assign ack_en = chip_sel_s && host_req_s;

    always_ff @(posedge mclk) begin
        if (rst) begin
            host_access_ack_oe <= 1'b0;
            host_access_ack_o <= 1'b0;
        end else if (clk_en) begin
            host_access_ack_oe <= ack_en && (ack_active_drive_sel || host_access_busy);
            host_access_ack_o <= ack_en && ack_active_drive_sel && !host_access_busy;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // external dma channel mapping, pins active low

    assign dma_ch7_req = ~pins_f.ext_dma_req_a;
    assign dma_ch6_req = ~pins_f.ext_dma_req_b;

    always_ff @(posedge mclk) begin
        if (rst) begin
            ext_dma_grant_a <= PIN_IDLE;
            ext_dma_grant_b <= PIN_IDLE;
        end else if (clk_en) begin
            ext_dma_grant_a <= ~dma_ch7_grant;
            ext_dma_grant_b <= ~dma_ch6_grant;
        end
    end

    // grants float with the rest of the bus
    assign ext_dma_grant_a_oe = bus_drive_en;
    assign ext_dma_grant_b_oe = bus_drive_en;

    ////////////////////////////////////////////////////////////////////////////////
    // checks

    sequence s_host_seen;
        clk_en && loaded_q && host_req_s && st_q == ST_ARB;
    endsequence

    sequence s_release_step;
        clk_en && st_q == ST_RELEASE;
    endsequence

    a_host_handoff: assert property (@(posedge mclk) disable iff (rst)
        s_host_seen ##1 s_release_step |=> grant_q && st_q == ST_HOST)
        else $error("host grant not given after release step");

    a_host_beats_proc: assert property (@(posedge mclk) disable iff (rst)
        s_host_seen |=> st_q == ST_RELEASE && $stable(mst_q))
        else $error("processor arbitration moved past host request");

    a_grant_held: assert property (@(posedge mclk) disable iff (rst)
        grant_q && host_req_s |=> grant_q)
        else $error("host grant dropped while request held");

    a_grant_release: assert property (@(posedge mclk) disable iff (rst)
        clk_en && st_q == ST_HOST && !host_req_s |=> !grant_q && st_q == ST_ARB)
        else $error("host grant kept after request released");

    a_float_on_grant: assert property (@(posedge mclk) disable iff (rst)
        !host_bus_grant_n_o && host_bus_grant_n_oe |-> !bus_drive_en)
        else $error("bus driven while host granted");

    a_grant_owner: assert property (@(posedge mclk) disable iff (rst)
        host_bus_grant_n_oe |-> st_q != ST_ARB)
        else $error("grant driven outside hand-over");

    a_ack_gate: assert property (@(posedge mclk) disable iff (rst)
        $rose(host_access_ack_oe) |-> $past(ack_en))
        else $error("acknowledge driven without select and request");

    a_ack_open_drain: assert property (@(posedge mclk) disable iff (rst)
        clk_en && !ack_active_drive_sel |=> !host_access_ack_o)
        else $error("acknowledge driven high in open drain mode");

    a_ack_wait: assert property (@(posedge mclk) disable iff (rst)
        clk_en && ack_en && host_access_busy |=> host_access_ack_oe && !host_access_ack_o)
        else $error("wait state not inserted");

    a_own_line: assert property (@(posedge mclk) disable iff (rst)
        (proc_bus_req_line_oe & ~own_mask) == '0 && $countones(proc_bus_req_line_oe) <= 1)
        else $error("foreign request line driven");

    a_fixed_lowest: assert property (@(posedge mclk) disable iff (rst)
        clk_en && loaded_q && st_q == ST_ARB && !host_req_s && !mst_holds
        && !pins_f.rotating_priority_sel && br_req[0] |=> mst_q == 3'h1)
        else $error("fixed priority did not pick line 1");

    a_core_override: assert property (@(posedge mclk) disable iff (rst)
        is_master && cpa_seen && dma_wants_bus |-> dma_suspend)
        else $error("background transfer not suspended");

endmodule

// ---- bench/host_peer_model.sv ----
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////////
// far side: host processor plus peer processors sharing the bus lines
module host_peer_model (
    input wire logic mclk,
    input wire logic host_want,
    input wire logic select_want,
    input wire logic [5:0] peer_want,
    input wire logic peer_override,
    output logic host_bus_req_n = 1'b1,
    output logic chip_sel_n = 1'b1,
    output logic [5:0] peer_line_n = 6'h3f,
    output logic peer_override_n = 1'b1
);
    ////////////////////////////////////////////////////////////////////////////
    // request held for as long as the host wants the bus
    always_ff @(posedge mclk) begin
        host_bus_req_n <= ~host_want;
    end
    // select only ever shown together with a pending host request
    always_ff @(posedge mclk) begin
        chip_sel_n <= ~(select_want & host_want);
    end
    // peers pull only their own lines, released lines float to the pull-up
    always_ff @(posedge mclk) begin
        peer_line_n <= ~peer_want;
    end
    always_ff @(posedge mclk) begin
        peer_override_n <= ~peer_override;
    end
endmodule

// ---- bench/host_multiproc_bus_arbiter_test.sv ----
`timescale 1ns/1ns
module host_multiproc_bus_arbiter_test;
    import bus_arb_pkg::*;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic clk_en = 1'b1;
    logic ga_oe, gb_oe;
    logic rotating_sel = 1'b0;
    logic host_want = 1'b0;
    logic select_want = 1'b0;
    logic [5:0] peer_want = 6'h00;
    logic peer_override = 1'b0;
    logic busy = 1'b0;
    logic ack_sel = 1'b0;
    logic core_wants = 1'b0;
    logic dma_wants = 1'b0;
    logic ext_a = 1'b1;
    logic ext_b = 1'b1;
    logic ch7g = 1'b0;
    logic ch6g = 1'b0;
    logic hbr_n, cs_n, ovr_peer_n, grant_o, grant_oe, ack_o, ack_oe;
    logic ovr_o, ovr_oe, drive_en, master, suspend, ga, gb, ch7r, ch6r;
    logic [5:0] peer_n, br_o, br_oe;
    int bad_count = 0;
    int checks = 0;
    int cycles = 0;
    // wired-and lines with pull-ups
    wire logic grant_wire = grant_oe ? grant_o : 1'b1;
    wire logic [5:0] br_wire = peer_n & (~br_oe | br_o);
    wire logic ovr_wire = ovr_peer_n & (~ovr_oe | ovr_o);

    host_peer_model host_peer_model_inst (.mclk(mclk), .host_want(host_want),
        .select_want(select_want), .peer_want(peer_want), .peer_override(peer_override),
        .host_bus_req_n(hbr_n), .chip_sel_n(cs_n), .peer_line_n(peer_n),
        .peer_override_n(ovr_peer_n));

    host_multiproc_bus_arbiter host_multiproc_bus_arbiter_inst (.mclk(mclk), .rst(rst),
        .clk_en(clk_en), .host_bus_req_n(hbr_n), .chip_sel_n(cs_n),
        .host_bus_grant_n_i(grant_wire), .host_bus_grant_n_o(grant_o),
        .host_bus_grant_n_oe(grant_oe), .host_access_ack_o(ack_o),
        .host_access_ack_oe(ack_oe), .host_access_busy(busy),
        .ack_active_drive_sel(ack_sel), .proc_bus_req_line_i(br_wire),
        .proc_bus_req_line_o(br_o), .proc_bus_req_line_oe(br_oe),
        .processor_number_straps(3'h1), .rotating_priority_sel(rotating_sel),
        .core_access_override_n_i(ovr_wire), .core_access_override_n_o(ovr_o),
        .core_access_override_n_oe(ovr_oe), .core_wants_bus(core_wants),
        .dma_wants_bus(dma_wants), .bus_drive_en(drive_en), .is_master(master),
        .dma_suspend(suspend), .ext_dma_req_a(ext_a), .ext_dma_req_b(ext_b),
        .ext_dma_grant_a(ga), .ext_dma_grant_a_oe(ga_oe), .ext_dma_grant_b(gb),
        .ext_dma_grant_b_oe(gb_oe), .dma_ch7_req(ch7r), .dma_ch6_req(ch6r),
        .dma_ch7_grant(ch7g), .dma_ch6_grant(ch6g));

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        forever #5 mclk = ~mclk;
    end
    // ceiling well above the fewer than two hundred cycles the scenarios need
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 5000) begin
            bad_count++;
            complete_run();
        end
    end

    task automatic chk(input string what, input logic [5:0] exp, input logic [5:0] got);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic complete_run();
        $display("mismatches %0d comparisons %0d", bad_count, checks);
        if (bad_count == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_master();
        @(posedge mclk) core_wants <= 1'b1;
        cyc(10);
        chk("own line enable", 6'h01, br_oe);
        chk("own line value", 6'h3e, br_o | ~br_oe);
        chk("master", 6'h01, 6'(master));
        chk("bus drive", 6'h01, 6'(drive_en));
    endtask
    task automatic t_host_ack();
        int n;
        // a peer request stands too, the host must still win
        @(posedge mclk) peer_want <= 6'h02;
        host_want <= 1'b1;
        select_want <= 1'b1;
        busy <= 1'b1;
        n = 0;
        while (grant_o !== 1'b0 && n < 12) begin
            cyc(1);
            n++;
        end
        chk("grant low", 6'h00, 6'(grant_o));
        chk("grant enable", 6'h01, 6'(grant_oe));
        chk("bus floated", 6'h00, 6'(drive_en));
        cyc(6);
        chk("ack wait oe", 6'h01, 6'(ack_oe));
        chk("ack wait value", 6'h00, 6'(ack_o));
        @(posedge mclk) busy <= 1'b0;
        cyc(2);
        chk("ack open drain", 6'h00, 6'(ack_oe));
        @(posedge mclk) ack_sel <= 1'b1;
        cyc(2);
        chk("ack active oe", 6'h01, 6'(ack_oe));
        chk("ack active value", 6'h01, 6'(ack_o));
        @(posedge mclk) select_want <= 1'b0;
        cyc(6);
        chk("ack unselected", 6'h00, 6'(ack_oe));
        chk("grant held", 6'h00, 6'(grant_o));
        @(posedge mclk) host_want <= 1'b0;
        peer_want <= 6'h00;
        n = 0;
        while (grant_o !== 1'b1 && n < 12) begin
            cyc(1);
            n++;
        end
        chk("grant released", 6'h01, 6'(grant_o));
        chk("grant enable off", 6'h00, 6'(grant_oe));
    endtask
    task automatic t_dma();
        @(posedge mclk) ext_a <= 1'b0;
        cyc(6);
        chk("ch7 req", 6'h01, {4'h0, ch7r, ch6r} >> 1);
        chk("ch6 idle", 6'h00, 6'(ch6r));
        @(posedge mclk) ch7g <= 1'b1;
        cyc(2);
        chk("grant a", 6'h01, {4'h0, ga, gb});
        chk("grant enables", 6'h03, {4'h0, ga_oe, gb_oe});
        @(posedge mclk) ext_a <= 1'b1;
        ch7g <= 1'b0;
        ext_b <= 1'b0;
        ch6g <= 1'b1;
        cyc(6);
        chk("ch6 req", 6'h01, {4'h0, ch7r, ch6r});
        chk("grant b", 6'h01, {4'h0, gb, ga});
        @(posedge mclk) ext_b <= 1'b1;
        ch6g <= 1'b0;
    endtask
    task automatic t_override();
        @(posedge mclk) dma_wants <= 1'b1;
        peer_override <= 1'b1;
        cyc(6);
        chk("dma suspended", 6'h01, 6'(suspend));
        @(posedge mclk) peer_override <= 1'b0;
        cyc(6);
        chk("dma resumed", 6'h00, 6'(suspend));
    endtask
    task automatic t_lose();
        // fixed priority: dropping our line hands the bus to line 2
        @(posedge mclk) core_wants <= 1'b0;
        dma_wants <= 1'b0;
        peer_want <= 6'h02;
        cyc(10);
        chk("lost master", 6'h00, 6'(master));
        chk("slave floated", 6'h00, 6'(drive_en));
        chk("dma grants floated", 6'h00, {4'h0, ga_oe, gb_oe});
        @(posedge mclk) core_wants <= 1'b1;
        cyc(2);
        chk("override drive", 6'h01, 6'(ovr_oe));
        chk("override value", 6'h00, 6'(ovr_o));
    endtask
    task automatic t_rotate();
        // line 2 was last master, so under rotation line 3 outranks our line 1
        @(posedge mclk) rotating_sel <= 1'b1;
        peer_want <= 6'h06;
        cyc(8);
        @(posedge mclk) peer_want <= 6'h04;
        cyc(10);
        chk("rotated past line 1", 6'h00, 6'(master));
        @(posedge mclk) peer_want <= 6'h00;
        cyc(10);
        chk("rotated to line 1", 6'h01, 6'(master));
        chk("master drives again", 6'h01, 6'(drive_en));
    endtask
    task automatic t_freeze();
        // with the enable low no flop moves, so a dropped want keeps the line low
        @(posedge mclk) clk_en <= 1'b0;
        core_wants <= 1'b0;
        cyc(8);
        chk("frozen master", 6'h01, 6'(master));
        chk("frozen own line", 6'h3e, br_o | ~br_oe);
        @(posedge mclk) clk_en <= 1'b1;
        core_wants <= 1'b1;
        cyc(2);
    endtask

    initial begin
        cyc(15);
        chk("reset grant", 6'h01, 6'(grant_o));
        chk("reset enables", 6'h00, br_oe | 6'(grant_oe) | 6'(ack_oe));
        @(posedge mclk) rst <= 1'b0;
        cyc(8);
        t_master();
        t_host_ack();
        t_dma();
        t_override();
        t_lose();
        t_rotate();
        t_freeze();
        complete_run();
    end
endmodule
